// ---- rtl/smcg_top.sv ----
// sleep mode clock gating, wake sequencing and the four i/o ports
// Notes on behaviour
// [R1] six sleep modes, chosen before sleep
// [R2] idle stops cpu, peripherals keep clocks
// [R3] power-down freezes oscillator; external interrupt wakes
// [R4] power-save keeps asynchronous timer counting
// [R5] adc noise mode keeps adc, async timer
// [R6] standby keeps main oscillator running only
// [R7] extended standby keeps oscillator and async timer
// [R8] ports go high impedance during reset
// [R9] debug pull-ups stay on when enabled
// [R10] long low on reset input resets clocklessly
// [R11] analog port: adc inputs or 8-bit i/o
// [R12] other ports: 8-bit i/o, per-bit pull-up
// [R13] gated clocks restart before cpu resumes
module smcg_top
    import smcg_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // sleep control from the cpu
    input wire logic SLEEP_REQ,
    input wire logic [MODE_W-1:0] SLEEP_MODE,
    // wake sources
    input wire logic EXT_IRQ,
    input wire logic ASYNC_TIMER_IRQ,
    input wire logic ADC_DONE_IRQ,
    input wire logic OTHER_IRQ,
    // configuration levels
    input wire logic ADC_EN,
    input wire logic JTAG_EN,
    // clock enables and status
    output logic CPU_CLK_EN,
    output logic IO_CLK_EN,
    output logic ADC_CLK_EN,
    output logic ASYNC_CLK_EN,
    output logic MAIN_OSC_EN,
    output logic SLEEPING,
    // analog shared port
    input wire logic [PORT_W-1:0] ANALOG_SHARED_PORT_PINS_OUT,
    input wire logic [PORT_W-1:0] ANALOG_SHARED_PORT_PINS_DIR,
    input wire logic [PORT_W-1:0] ANALOG_SHARED_PORT_PINS_PU_REQ,
    input wire logic [PORT_W-1:0] ANALOG_SHARED_PORT_PINS_I,
    output logic [PORT_W-1:0] ANALOG_SHARED_PORT_PINS_O,
    output logic [PORT_W-1:0] ANALOG_SHARED_PORT_PINS_OE,
    output logic [PORT_W-1:0] ANALOG_SHARED_PORT_PINS_PU,
    output logic [PORT_W-1:0] ANALOG_SHARED_PORT_PINS_VAL,
    // second port
    input wire logic [PORT_W-1:0] SECOND_PORT_PINS_OUT,
    input wire logic [PORT_W-1:0] SECOND_PORT_PINS_DIR,
    input wire logic [PORT_W-1:0] SECOND_PORT_PINS_PU_REQ,
    input wire logic [PORT_W-1:0] SECOND_PORT_PINS_I,
    output logic [PORT_W-1:0] SECOND_PORT_PINS_O,
    output logic [PORT_W-1:0] SECOND_PORT_PINS_OE,
    output logic [PORT_W-1:0] SECOND_PORT_PINS_PU,
    output logic [PORT_W-1:0] SECOND_PORT_PINS_VAL,
    // third port
    input wire logic [PORT_W-1:0] THIRD_PORT_PINS_OUT,
    input wire logic [PORT_W-1:0] THIRD_PORT_PINS_DIR,
    input wire logic [PORT_W-1:0] THIRD_PORT_PINS_PU_REQ,
    input wire logic [PORT_W-1:0] THIRD_PORT_PINS_I,
    output logic [PORT_W-1:0] THIRD_PORT_PINS_O,
    output logic [PORT_W-1:0] THIRD_PORT_PINS_OE,
    output logic [PORT_W-1:0] THIRD_PORT_PINS_PU,
    output logic [PORT_W-1:0] THIRD_PORT_PINS_VAL,
    // fourth port
    input wire logic [PORT_W-1:0] FOURTH_PORT_PINS_OUT,
    input wire logic [PORT_W-1:0] FOURTH_PORT_PINS_DIR,
    input wire logic [PORT_W-1:0] FOURTH_PORT_PINS_PU_REQ,
    input wire logic [PORT_W-1:0] FOURTH_PORT_PINS_I,
    output logic [PORT_W-1:0] FOURTH_PORT_PINS_O,
    output logic [PORT_W-1:0] FOURTH_PORT_PINS_OE,
    output logic [PORT_W-1:0] FOURTH_PORT_PINS_PU,
    output logic [PORT_W-1:0] FOURTH_PORT_PINS_VAL
);

    // ******************************
    // mode tables
    // ******************************
    function automatic logic [CLK_W-1:0] mode_clocks(input logic [MODE_W-1:0] m);
        logic [CLK_W-1:0] c;
        c = CLKS_IDLE;
        unique case (m)
            MODE_IDLE: c = CLKS_IDLE; // [R2]
            MODE_ADC_NR: c = CLKS_ADC_NR; // [R5]
            MODE_PSAVE: c = CLKS_PSAVE; // [R4]
            MODE_PDOWN: c = CLKS_PDOWN; // [R3]
            MODE_STBY: c = CLKS_STBY; // [R6]
            MODE_EXT_STBY: c = CLKS_EXT_STBY; // [R7]
            default: c = CLKS_IDLE;
        endcase
        return c;
    endfunction

    function automatic logic [WAKE_W-1:0] mode_wakes(input logic [MODE_W-1:0] m);
        logic [WAKE_W-1:0] w;
        w = WAKE_ALL;
        unique case (m)
            MODE_IDLE: w = WAKE_ALL;
            MODE_ADC_NR: w = WAKE_ADC_NR;
            MODE_PSAVE: w = WAKE_ASYNC;
            MODE_PDOWN: w = WAKE_EXT; // [R3]
            MODE_STBY: w = WAKE_EXT;
            MODE_EXT_STBY: w = WAKE_ASYNC;
            default: w = WAKE_ALL;
        endcase
        return w;
    endfunction

    // ******************************
    // sleep sequencer
    // ******************************
    smcg_state_e st_q, st_d;
    logic [MODE_W-1:0] mode_q, mode_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CLK_W-1:0] clks_q, clks_d;
    logic sleeping_q, sleeping_d;
    logic [WAKE_W-1:0] wake_src;
    logic wake;

    always_comb begin
        st_d = st_q;
        mode_d = mode_q;
        cnt_d = cnt_q;
        clks_d = clks_q;
        wake_src = {OTHER_IRQ, ADC_DONE_IRQ, ASYNC_TIMER_IRQ, EXT_IRQ};
        wake = |(wake_src & mode_wakes(mode_q));
        unique case (st_q)
            ST_RUN: begin
                clks_d = CLKS_RUN;
                if (SLEEP_REQ) begin
                    mode_d = SLEEP_MODE; // [R1]
                    clks_d = mode_clocks(SLEEP_MODE); // [R1]
                    st_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake) begin
                    clks_d[CK_OSC] = 1'b1;
                    if (clks_q[CK_OSC]) begin
                        st_d = ST_CLK_ON; // [R6]
                    end else begin
                        cnt_d = OSC_START_CYC;
                        st_d = ST_OSC_WAIT;
                    end
                end
            end
            ST_OSC_WAIT: begin
                if (cnt_q <= CNT_ONE) begin
                    cnt_d = CNT_ZERO;
                    st_d = ST_CLK_ON;
                end else begin
                    cnt_d = cnt_q - CNT_ONE;
                end
            end
            ST_CLK_ON: begin
                // peripheral clocks first, cpu one cycle later
                clks_d = CLKS_RUN & ~(CLK_W'(1) << CK_CPU); // [R13]
                st_d = ST_RUN; // [R13]
            end
        endcase
        sleeping_d = (st_d != ST_RUN);
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin // [R10]
            st_q <= ST_RUN;
            mode_q <= MODE_RST;
            cnt_q <= CNT_ZERO;
            clks_q <= CLKS_RESET;
            sleeping_q <= 1'b0;
        end else begin
            st_q <= st_d;
            mode_q <= mode_d;
            cnt_q <= cnt_d;
            clks_q <= clks_d;
            sleeping_q <= sleeping_d;
        end
    end

    assign CPU_CLK_EN = clks_q[CK_CPU];
    assign IO_CLK_EN = clks_q[CK_IO];
    assign ADC_CLK_EN = clks_q[CK_ADC];
    assign ASYNC_CLK_EN = clks_q[CK_ASYNC];
    assign MAIN_OSC_EN = clks_q[CK_OSC];
    assign SLEEPING = sleeping_q;

    // ******************************
    // i/o ports
    // ******************************
    smcg_port #(.PU_KEEP(PORT_RST)) u_analog_port ( // [R11]
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .out_data(ANALOG_SHARED_PORT_PINS_OUT),
        .dir(ANALOG_SHARED_PORT_PINS_DIR),
        .pu_req(ANALOG_SHARED_PORT_PINS_PU_REQ),
        .digital_off(ADC_EN),
        .keep_en(1'b0),
        .pin_in(ANALOG_SHARED_PORT_PINS_I),
        .pin_o(ANALOG_SHARED_PORT_PINS_O),
        .pin_oe(ANALOG_SHARED_PORT_PINS_OE),
        .pin_pu(ANALOG_SHARED_PORT_PINS_PU),
        .pin_val(ANALOG_SHARED_PORT_PINS_VAL)
    );

    smcg_port #(.PU_KEEP(PORT_RST)) u_second_port ( // [R12]
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .out_data(SECOND_PORT_PINS_OUT),
        .dir(SECOND_PORT_PINS_DIR),
        .pu_req(SECOND_PORT_PINS_PU_REQ),
        .digital_off(1'b0),
        .keep_en(1'b0),
        .pin_in(SECOND_PORT_PINS_I),
        .pin_o(SECOND_PORT_PINS_O),
        .pin_oe(SECOND_PORT_PINS_OE),
        .pin_pu(SECOND_PORT_PINS_PU),
        .pin_val(SECOND_PORT_PINS_VAL)
    );

    smcg_port #(.PU_KEEP(JTAG_PU_MASK)) u_third_port ( // [R12]
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .out_data(THIRD_PORT_PINS_OUT),
        .dir(THIRD_PORT_PINS_DIR),
        .pu_req(THIRD_PORT_PINS_PU_REQ),
        .digital_off(1'b0),
        .keep_en(JTAG_EN), // [R9]
        .pin_in(THIRD_PORT_PINS_I),
        .pin_o(THIRD_PORT_PINS_O),
        .pin_oe(THIRD_PORT_PINS_OE),
        .pin_pu(THIRD_PORT_PINS_PU),
        .pin_val(THIRD_PORT_PINS_VAL)
    );

    smcg_port #(.PU_KEEP(PORT_RST)) u_fourth_port ( // [R12]
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .out_data(FOURTH_PORT_PINS_OUT),
        .dir(FOURTH_PORT_PINS_DIR),
        .pu_req(FOURTH_PORT_PINS_PU_REQ),
        .digital_off(1'b0),
        .keep_en(1'b0),
        .pin_in(FOURTH_PORT_PINS_I),
        .pin_o(FOURTH_PORT_PINS_O),
        .pin_oe(FOURTH_PORT_PINS_OE),
        .pin_pu(FOURTH_PORT_PINS_PU),
        .pin_val(FOURTH_PORT_PINS_VAL)
    );

endmodule // smcg_top

// ---- rtl/smcg_pkg.sv ----
// shared constants for the sleep-mode clock gating block
package smcg_pkg;

    // ******************************
    // widths
    // ******************************
    localparam int PORT_W = 8;
    localparam int MODE_W = 3;
    localparam int CNT_W = 12;
    localparam int CLK_W = 5;
    localparam int WAKE_W = 4;

    // ******************************
    // sleep mode codes on the mode select input
    // ******************************
    localparam logic [MODE_W-1:0] MODE_IDLE = 3'h0;
    localparam logic [MODE_W-1:0] MODE_ADC_NR = 3'h1;
    localparam logic [MODE_W-1:0] MODE_PSAVE = 3'h2;
    localparam logic [MODE_W-1:0] MODE_PDOWN = 3'h3;
    localparam logic [MODE_W-1:0] MODE_STBY = 3'h4;
    localparam logic [MODE_W-1:0] MODE_EXT_STBY = 3'h5;

    // ******************************
    // clock enable vector {osc, async, adc, io, cpu}
    // ******************************
    localparam int CK_CPU = 0;
    localparam int CK_IO = 1;
    localparam int CK_ADC = 2;
    localparam int CK_ASYNC = 3;
    localparam int CK_OSC = 4;
    localparam logic [CLK_W-1:0] CLKS_RUN = 5'h1f;
    localparam logic [CLK_W-1:0] CLKS_IDLE = 5'h1e;
    localparam logic [CLK_W-1:0] CLKS_ADC_NR = 5'h1c;
    localparam logic [CLK_W-1:0] CLKS_PSAVE = 5'h08;
    localparam logic [CLK_W-1:0] CLKS_PDOWN = 5'h00;
    localparam logic [CLK_W-1:0] CLKS_STBY = 5'h10;
    localparam logic [CLK_W-1:0] CLKS_EXT_STBY = 5'h18;
    localparam logic [CLK_W-1:0] CLKS_RESET = 5'h1f;

    // ******************************
    // wake source vector {other, adc, async, ext}
    // ******************************
    localparam logic [WAKE_W-1:0] WAKE_ALL = 4'hf;
    localparam logic [WAKE_W-1:0] WAKE_ADC_NR = 4'h7;
    localparam logic [WAKE_W-1:0] WAKE_ASYNC = 4'h3;
    localparam logic [WAKE_W-1:0] WAKE_EXT = 4'h1;

    // ******************************
    // oscillator restart time
    // ******************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int OSC_START_NS = 16000;
    localparam logic [CNT_W-1:0] OSC_START_CYC =
        CNT_W'((OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;

    // ******************************
    // port reset values, debug pull-up bits (tdi 5, tms 3, tck 2)
    // ******************************
    localparam logic [PORT_W-1:0] PORT_RST = 8'h00;
    localparam logic [PORT_W-1:0] JTAG_PU_MASK = 8'h2c;
    localparam logic [MODE_W-1:0] MODE_RST = 3'h0;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_SLEEP,
        ST_OSC_WAIT,
        ST_CLK_ON
    } smcg_state_e;

endpackage

// ---- rtl/smcg_port.sv ----
// one 8-bit bidirectional port with per-bit pull-up
module smcg_port
    import smcg_pkg::*;
#(
    parameter logic [PORT_W-1:0] PU_KEEP = 8'h00
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // core side
    input wire logic [PORT_W-1:0] out_data,
    input wire logic [PORT_W-1:0] dir,
    input wire logic [PORT_W-1:0] pu_req,
    input wire logic digital_off,
    input wire logic keep_en,
    // pad side
    input wire logic [PORT_W-1:0] pin_in,
    output logic [PORT_W-1:0] pin_o,
    output logic [PORT_W-1:0] pin_oe,
    output logic [PORT_W-1:0] pin_pu,
    output logic [PORT_W-1:0] pin_val
);

    // ******************************
    // per-bit pad logic
    // ******************************
    genvar i;
    generate
        for (i = 0; i < PORT_W; i++) begin : g_bit
            logic o_q, o_d, oe_q, oe_d, pu_q, pu_d, val_q, val_d;

            always_comb begin
                o_d = out_data[i];
                oe_d = dir[i] & ~digital_off;
                pu_d = (~dir[i] & pu_req[i] & ~digital_off) | (PU_KEEP[i] & keep_en); // [R9]
                val_d = pin_in[i];
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    o_q <= PORT_RST[i];
                    oe_q <= PORT_RST[i]; // [R8]
                    pu_q <= PU_KEEP[i]; // [R9]
                    val_q <= PORT_RST[i];
                end else begin
                    o_q <= o_d;
                    oe_q <= oe_d;
                    pu_q <= pu_d;
                    val_q <= val_d;
                end
            end

            assign pin_o[i] = o_q;
            assign pin_oe[i] = oe_q;
            assign pin_pu[i] = pu_q;
            assign pin_val[i] = val_q;
        end
    endgenerate

endmodule // smcg_port

// ---- tb/smcg_monitor.sv ----
// assertion checker on the block's top-level ports
module smcg_monitor
    import smcg_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // controls
    input wire logic SLEEP_REQ,
    input wire logic [MODE_W-1:0] SLEEP_MODE,
    input wire logic EXT_IRQ,
    input wire logic ADC_EN,
    input wire logic JTAG_EN,
    // clock enables
    input wire logic CPU_CLK_EN,
    input wire logic IO_CLK_EN,
    input wire logic ADC_CLK_EN,
    input wire logic ASYNC_CLK_EN,
    input wire logic MAIN_OSC_EN,
    input wire logic SLEEPING,
    // ports
    input wire logic [PORT_W-1:0] SECOND_PORT_PINS_DIR,
    input wire logic [PORT_W-1:0] SECOND_PORT_PINS_OE,
    input wire logic [PORT_W-1:0] ANALOG_SHARED_PORT_PINS_OE,
    input wire logic [PORT_W-1:0] THIRD_PORT_PINS_PU
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [CLK_W-1:0] ens;
    logic take;
    assign ens = {MAIN_OSC_EN, ASYNC_CLK_EN, ADC_CLK_EN, IO_CLK_EN, CPU_CLK_EN};
    assign take = SLEEP_REQ && !SLEEPING;
    // ******
    // properties
    // ******
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    idle_clocks_a: assert property (take && SLEEP_MODE == MODE_IDLE |=> ens == 5'h1e)
        else $error("idle enables wrong");
    adc_noise_a: assert property (take && SLEEP_MODE == MODE_ADC_NR |=> ens == 5'h1c)
        else $error("adc noise enables wrong");
    pdown_hold_a: assert property (ens == 5'h00 && !EXT_IRQ |=> ens == 5'h00)
        else $error("power-down left without wake");
    cpu_last_a: assert property ($rose(CPU_CLK_EN) |-> $past(IO_CLK_EN) && IO_CLK_EN)
        else $error("cpu clock before peripherals");
    reset_state_a: assert property (disable iff (1'b0)
        !RST_N |-> ens == 5'h1f && !SLEEPING && SECOND_PORT_PINS_OE == 8'h00
        && ANALOG_SHARED_PORT_PINS_OE == 8'h00) else $error("reset state wrong");
    debug_pullup_a: assert property (JTAG_EN |=> (THIRD_PORT_PINS_PU & 8'h2c) == 8'h2c)
        else $error("debug pull-ups off");
    adc_port_a: assert property (ADC_EN |=> ANALOG_SHARED_PORT_PINS_OE == 8'h00)
        else $error("analog port driven under adc");
    port_dir_a: assert property (
        $past(RST_N) |-> SECOND_PORT_PINS_OE == $past(SECOND_PORT_PINS_DIR))
        else $error("drive enable not following direction");
endmodule  // smcg_monitor

bind smcg_top smcg_monitor smcg_monitor_inst (.SYS_CLK, .RST_N, .SLEEP_REQ, .SLEEP_MODE,
    .EXT_IRQ, .ADC_EN, .JTAG_EN, .CPU_CLK_EN, .IO_CLK_EN, .ADC_CLK_EN, .ASYNC_CLK_EN,
    .MAIN_OSC_EN, .SLEEPING, .SECOND_PORT_PINS_DIR, .SECOND_PORT_PINS_OE,
    .ANALOG_SHARED_PORT_PINS_OE, .THIRD_PORT_PINS_PU);

// ---- tb/smcg_far_model.sv ----
// far-side model: cpu sleep requests and second port pads
module smcg_far
    import smcg_pkg::*;
(
    // clock and bench request
    input wire logic clk,
    input wire logic go,
    input wire logic [MODE_W-1:0] mode_in,
    // to the block
    output logic req,
    output logic [MODE_W-1:0] mode,
    // pads
    input wire logic [PORT_W-1:0] o,
    input wire logic [PORT_W-1:0] oe,
    input wire logic [PORT_W-1:0] pu,
    output logic [PORT_W-1:0] pad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tgl = 1'b0;
    initial req = 1'b0;
    initial mode = MODE_IDLE;
    // one-cycle request, mode chosen with it
    always @(negedge clk) begin
        req <= go;
        mode <= mode_in;
        tgl <= ~tgl;
    end
    // undriven lines without pull-up wander
    assign pad = (oe & o) | (~oe & pu) | (~oe & ~pu & {PORT_W{tgl}});
endmodule  // smcg_far

// ---- tb/smcg_top_tb.sv ----
// self-checking bench for the sleep mode clock gating block
module smcg_top_tb
    import smcg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b1;
    logic go = 1'b0;
    logic adc_en = 1'b0;
    logic jtag_en = 1'b1;
    logic req, cpu, io, adc, asy, osc, slp;
    logic [MODE_W-1:0] mode_in = MODE_IDLE;
    logic [MODE_W-1:0] mode;
    logic [WAKE_W-1:0] irq = 4'h0;
    logic [PORT_W-1:0] p_out = 8'h00;
    logic [PORT_W-1:0] p_dir = 8'h00;
    logic [PORT_W-1:0] p_pu = 8'h00;
    logic [PORT_W-1:0] s_out = 8'h00;
    logic [PORT_W-1:0] s_dir = 8'h00;
    logic [PORT_W-1:0] s_pu = 8'h00;
    logic [PORT_W-1:0] s_i, s_o, s_oe, s_pul, s_val, a_oe, a_pu, t_pu, t_oe;
    logic [PORT_W-1:0] t_o, t_val, f_o, f_oe, f_pu, f_val;
    logic [CLK_W-1:0] ens;
    int n_mismatch = 0;
    int comparisons = 0;
    int wake_cyc;
    assign ens = {osc, asy, adc, io, cpu};
    smcg_top smcg_top_inst (
        .SYS_CLK(clk), .RST_N(rst_n), .SLEEP_REQ(req), .SLEEP_MODE(mode),
        .EXT_IRQ(irq[0]), .ASYNC_TIMER_IRQ(irq[1]), .ADC_DONE_IRQ(irq[2]), .OTHER_IRQ(irq[3]),
        .ADC_EN(adc_en), .JTAG_EN(jtag_en), .CPU_CLK_EN(cpu), .IO_CLK_EN(io),
        .ADC_CLK_EN(adc), .ASYNC_CLK_EN(asy), .MAIN_OSC_EN(osc), .SLEEPING(slp),
        .ANALOG_SHARED_PORT_PINS_OUT(p_out), .ANALOG_SHARED_PORT_PINS_DIR(p_dir),
        .ANALOG_SHARED_PORT_PINS_PU_REQ(p_pu), .ANALOG_SHARED_PORT_PINS_I(p_out),
        .ANALOG_SHARED_PORT_PINS_O(), .ANALOG_SHARED_PORT_PINS_OE(a_oe),
        .ANALOG_SHARED_PORT_PINS_PU(a_pu), .ANALOG_SHARED_PORT_PINS_VAL(),
        .SECOND_PORT_PINS_OUT(s_out), .SECOND_PORT_PINS_DIR(s_dir), .SECOND_PORT_PINS_PU_REQ(s_pu),
        .SECOND_PORT_PINS_I(s_i), .SECOND_PORT_PINS_O(s_o), .SECOND_PORT_PINS_OE(s_oe),
        .SECOND_PORT_PINS_PU(s_pul), .SECOND_PORT_PINS_VAL(s_val),
        .THIRD_PORT_PINS_OUT(p_out), .THIRD_PORT_PINS_DIR(p_dir), .THIRD_PORT_PINS_PU_REQ(p_pu),
        .THIRD_PORT_PINS_I(p_out), .THIRD_PORT_PINS_O(t_o), .THIRD_PORT_PINS_OE(t_oe),
        .THIRD_PORT_PINS_PU(t_pu), .THIRD_PORT_PINS_VAL(t_val),
        .FOURTH_PORT_PINS_OUT(p_out), .FOURTH_PORT_PINS_DIR(p_dir), .FOURTH_PORT_PINS_PU_REQ(p_pu),
        .FOURTH_PORT_PINS_I(p_out), .FOURTH_PORT_PINS_O(f_o), .FOURTH_PORT_PINS_OE(f_oe),
        .FOURTH_PORT_PINS_PU(f_pu), .FOURTH_PORT_PINS_VAL(f_val)
    );
    smcg_far smcg_far_inst (.clk(clk), .go(go), .mode_in(mode_in), .req(req), .mode(mode),
        .o(s_o), .oe(s_oe), .pu(s_pul), .pad(s_i));
    // ******
    // helpers
    // ******
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic sleep_in(input logic [MODE_W-1:0] m);
        @(negedge clk);
        mode_in <= m;
        go <= 1'b1;
        @(negedge clk);
        go <= 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic wake_up(input int src);
        logic prev_io;
        prev_io = 1'b0;
        wake_cyc = 0;
        irq = WAKE_W'(1 << src);
        while (cpu !== 1'b1 && wake_cyc < 3000) begin
            prev_io = io;
            @(negedge clk);
            wake_cyc++;
        end
        check("io before cpu", prev_io, 1'b1);
        check("awake", slp, 1'b0);
        irq = 4'h0;
    endtask
    // ******
    // scenarios
    // ******
    task automatic t_ports();
        s_dir = 8'hff;
        s_out = 8'ha5;
        p_dir = 8'h0f;
        p_out = 8'h3c;
        p_pu = 8'hf0;
        jtag_en = 1'b0;
        repeat (3) @(negedge clk);
        check("drive", {s_oe, s_o, s_val}, 24'hffa5a5);
        check("analog port", {a_oe, a_pu}, 16'h0ff0);
        check("debug pu off", t_pu, 8'hf0);
        check("third port", {t_oe, t_o, t_val}, 24'h0f3c3c);
        check("fourth port", {f_oe, f_o, f_pu, f_val}, 32'h0f3cf03c);
        s_dir = 8'h00;
        s_pu = 8'h0f;
        adc_en = 1'b1;
        jtag_en = 1'b1;
        repeat (3) @(negedge clk);
        check("pull-up", {s_pul, s_val & 8'h0f}, 16'h0f0f);
        check("adc owns port", {a_oe, a_pu}, 16'h0000);
        check("debug pu on", t_pu, 8'hfc);
        adc_en = 1'b0;
    endtask
    task automatic t_modes();
        logic [CLK_W-1:0] tbl [6] = '{5'h1e, 5'h1c, 5'h08, 5'h00, 5'h10, 5'h18};
        int good [6] = '{3, 2, 1, 0, 0, 1};
        int bad [6] = '{0, 3, 2, 1, 1, 2};
        for (int i = 0; i < 6; i++) begin
            sleep_in(MODE_W'(i));
            check("asleep", slp, 1'b1);
            check("mode enables", ens, tbl[i]);
            if (i > 0) begin
                irq = WAKE_W'(1 << bad[i]);
                repeat (4) @(negedge clk);
                check("stray wake", ens, tbl[i]);
                irq = 4'h0;
            end
            wake_up(good[i]);
            if (i == 3) begin
                check("osc restart", wake_cyc >= 2000, 1'b1);
            end
        end
    endtask
    task automatic t_refused();
        sleep_in(MODE_IDLE);
        sleep_in(MODE_PDOWN);
        check("ignored request", ens, 5'h1e);
        wake_up(3);
        sleep_in(3'h6);
        check("spare code as idle", ens, 5'h1e);
        wake_up(3);
    endtask
    task automatic t_reset();
        sleep_in(MODE_PDOWN);
        s_dir = 8'hff;
        @(negedge clk);
        rst_n = 1'b0;
        #1;
        check("reset enables", {slp, ens}, 6'h1f);
        check("reset drive", {a_oe, s_oe, t_oe}, 24'h0);
        check("reset pullups", t_pu, 8'h2c);
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        s_dir = 8'h00;
        sleep_in(MODE_IDLE);
        check("sleep after reset", slp, 1'b1);
    endtask
    initial begin
        forever #4 clk = ~clk;
    end
    initial begin
        #200000;
        n_mismatch++;
        close_out();
    end
    initial begin
        #1 rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        t_ports();
        t_modes();
        t_refused();
        t_reset();
        close_out();
    end
endmodule  // smcg_top_tb
